// ### hdl/gpgi_pkg.sv
package gpgi_pkg;
  // sizes
  localparam int NCH      = 8;
  localparam int NPIN     = 64;
  localparam int PORTW    = 32;
  localparam int SRCW     = 6;
  localparam int AW       = 16;
  localparam int OFFW     = 14;

  // address regions, selected by the two top address bits
  localparam logic [1:0] RGN_PINT = 2'h0;
  localparam logic [1:0] RGN_GRP0 = 2'h1;
  localparam logic [1:0] RGN_GRP1 = 2'h2;
  localparam logic [1:0] RGN_PORT = 2'h3;

  // pin interrupt block offsets
  localparam logic [OFFW-1:0] OFF_SEL     = 14'h0000;
  localparam logic [OFFW-1:0] OFF_ENR     = 14'h0004;
  localparam logic [OFFW-1:0] OFF_ENR_SET = 14'h0008;
  localparam logic [OFFW-1:0] OFF_ENR_CLR = 14'h000C;
  localparam logic [OFFW-1:0] OFF_ENF     = 14'h0010;
  localparam logic [OFFW-1:0] OFF_ENF_SET = 14'h0014;
  localparam logic [OFFW-1:0] OFF_ENF_CLR = 14'h0018;
  localparam logic [OFFW-1:0] OFF_RISE    = 14'h001C;
  localparam logic [OFFW-1:0] OFF_FALL    = 14'h0020;
  localparam logic [OFFW-1:0] OFF_IST     = 14'h0024;
  localparam logic [8:0]      SRC_HI      = 9'h002;  // 0x040..0x05C

  // grouped block offsets and control bits
  localparam logic [OFFW-1:0] GOFF_CTRL  = 14'h0000;
  localparam logic [OFFW-1:0] GOFF_POL_A = 14'h0020;
  localparam logic [OFFW-1:0] GOFF_POL_B = 14'h0024;
  localparam logic [OFFW-1:0] GOFF_ENA_A = 14'h0040;
  localparam logic [OFFW-1:0] GOFF_ENA_B = 14'h0044;
  localparam int CTRL_INT_BIT  = 0;
  localparam int CTRL_COMB_BIT = 1;
  localparam int CTRL_TRIG_BIT = 2;
  localparam logic [PORTW-1:0] POL_RST = 32'hFFFFFFFF;

  // port block offsets
  localparam logic [5:0]      WPIN_HI   = 6'h10;    // 0x1000..0x10FC
  localparam logic [OFFW-1:0] POFF_DIR_A = 14'h2000;
  localparam logic [OFFW-1:0] POFF_DIR_B = 14'h2004;
  localparam logic [OFFW-1:0] POFF_PIN_A = 14'h2100;
  localparam logic [OFFW-1:0] POFF_PIN_B = 14'h2104;
  localparam logic [OFFW-1:0] POFF_SET_A = 14'h2200;
  localparam logic [OFFW-1:0] POFF_SET_B = 14'h2204;
  localparam logic [OFFW-1:0] POFF_CLR_A = 14'h2280;
  localparam logic [OFFW-1:0] POFF_CLR_B = 14'h2284;
  localparam logic [OFFW-1:0] POFF_NOT_A = 14'h2300;
  localparam logic [OFFW-1:0] POFF_NOT_B = 14'h2304;

  // channel detection type
  typedef enum logic {
    GPGI_EDGE  = 1'b0,
    GPGI_LEVEL = 1'b1
  } gpgi_mode_type;

  // register port request
  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [AW-1:0]    addr;
    logic [PORTW-1:0] wdata;
  } gpgi_bus_type;
endpackage : gpgi_pkg

// ### hdl/gpgi_top.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module gpgi_group
  import gpgi_pkg::*;
(
  // clock and reset
  input  wire logic            ref_clk_i,
  input  wire logic            resetn_i,
  // pins
  input  wire logic [NPIN-1:0] pin_sync_i,
  input  wire logic [NPIN-1:0] pin_raw_i,
  input  wire logic            sleep_i,
  // register access
  input  wire logic            we_i,
  input  wire logic [OFFW-1:0] off_i,
  input  wire logic [PORTW-1:0] wdata_i,
  output logic [PORTW-1:0]     rdata_o,
  // requests
  output logic                 irq_o,
  output logic                 wake_o
);
  logic [NPIN-1:0] pol_r;
  logic [NPIN-1:0] ena_r;
  logic            comb_r;
  logic            trig_r;
  logic            int_r;
  logic            match_prev_r;
  logic            int_nxt;

  // pattern evaluation on synchronised and raw pins
  wire [NPIN-1:0] act_w     = ~(pin_sync_i ^ pol_r);
  wire [NPIN-1:0] act_raw_w = ~(pin_raw_i ^ pol_r);
  wire match_w = comb_r ? ((|ena_r) & (&(~ena_r | act_w)))
                        : (|(ena_r & act_w));
  wire match_raw_w = comb_r ? ((|ena_r) & (&(~ena_r | act_raw_w)))
                            : (|(ena_r & act_raw_w));
  wire hit_w = trig_r ? match_w : (match_w & ~match_prev_r);
  wire wr_ctrl_w  = we_i && (off_i == GOFF_CTRL);
  wire clr_int_w  = wr_ctrl_w && wdata_i[CTRL_INT_BIT];

  // a new hit in the clearing cycle keeps the request up
  assign int_nxt = hit_w | (int_r & ~clr_int_w);
  // the wake path skips the synchroniser so it works with clocks stopped;
  // the synchronised request follows three cycles or more later
  assign wake_o  = sleep_i & match_raw_w;
  assign irq_o   = int_r;

  // read selection
  assign rdata_o =
    (off_i == GOFF_CTRL)  ? {29'h0000000, trig_r, comb_r, int_r} :
    (off_i == GOFF_POL_A) ? pol_r[PORTW-1:0] :
    (off_i == GOFF_POL_B) ? pol_r[NPIN-1:PORTW] :
    (off_i == GOFF_ENA_A) ? ena_r[PORTW-1:0] :
    (off_i == GOFF_ENA_B) ? ena_r[NPIN-1:PORTW] : 32'h00000000;

  // configuration and request state
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pol_r        <= {POL_RST, POL_RST};
      ena_r        <= '0;
      comb_r       <= 1'b0;
      trig_r       <= 1'b0;
      int_r        <= 1'b0;
      match_prev_r <= 1'b0;
    end else begin
      int_r        <= int_nxt;
      match_prev_r <= match_w;
      if (wr_ctrl_w) begin
        comb_r <= wdata_i[CTRL_COMB_BIT];
        trig_r <= wdata_i[CTRL_TRIG_BIT];
      end
      if (we_i && off_i == GOFF_POL_A) pol_r[PORTW-1:0]    <= wdata_i;
      if (we_i && off_i == GOFF_POL_B) pol_r[NPIN-1:PORTW] <= wdata_i;
      if (we_i && off_i == GOFF_ENA_A) ena_r[PORTW-1:0]    <= wdata_i;
      if (we_i && off_i == GOFF_ENA_B) ena_r[NPIN-1:PORTW] <= wdata_i;
    end
  end

  // checks
  a_grp_clear_w1: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i) (clr_int_w && !hit_w) |=> !int_r)
    else $error("group request not cleared by write");
  a_grp_level_hit: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i) (trig_r && match_w) |=> int_r)
    else $error("level group match did not raise request");
  a_grp_edge_once: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    (!trig_r && match_w && match_prev_r && !int_r) |=> !int_r)
    else $error("edge group fired on a held match");
endmodule : gpgi_group

////////////////////////////////////////////////////////////////////////////////
module gpgi_top
  import gpgi_pkg::*;
#(
  parameter logic [NPIN-1:0] PIN_PRESENT = 64'hFFFFFFFFFFFFFFFF
)(
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              resetn_i,
  // register port
  input  wire gpgi_bus_type      bus_i,
  output logic [PORTW-1:0]       rdata_o,
  // pins
  input  wire logic [NPIN-1:0]   pin_in_i,
  output logic [NPIN-1:0]        pin_out_o,
  output logic [NPIN-1:0]        pin_oe_o,
  // power state and requests
  input  wire logic              sleep_i,
  output logic [NCH-1:0]         pint_irq_o,
  output logic [1:0]             grp_irq_o,
  output logic [1:0]             grp_wake_o
);
  logic [NPIN-1:0]  sync1_r;
  logic [NPIN-1:0]  sync2_r;
  logic [NPIN-1:0]  prev_r;
  logic [NPIN-1:0]  dir_r;
  logic [NPIN-1:0]  out_r;
  logic [NPIN-1:0]  out_nxt;
  logic [NCH-1:0]   edge_level_select_r;
  logic [NCH-1:0]   enr_r;
  logic [NCH-1:0]   enf_r;
  logic [NCH-1:0]   rise_r;
  logic [NCH-1:0]   fall_r;
  logic [NCH-1:0]   ist_r;
  logic [NCH-1:0]   enr_nxt;
  logic [NCH-1:0]   enf_nxt;
  logic [NCH-1:0]   rise_nxt;
  logic [NCH-1:0]   fall_nxt;
  logic [NCH-1:0]   ist_nxt;
  logic [NCH-1:0]   ch_lvl_w;
  logic [NCH-1:0]   ch_rev_w;
  logic [NCH-1:0]   ch_fev_w;
  logic [SRCW-1:0]  src_r [NCH];
  logic [PORTW-1:0] rdata_r;
  logic [PORTW-1:0] grp0_rd_w;
  logic [PORTW-1:0] grp1_rd_w;
  logic [1:0]       grp_irq_w;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  wire [1:0]      rgn_w  = bus_i.addr[AW-1:AW-2];
  wire [OFFW-1:0] off_w  = bus_i.addr[OFFW-1:0];
  wire [PORTW-1:0] wd_w  = bus_i.wdata;
  wire pint_we_w = bus_i.wr && (rgn_w == RGN_PINT);
  wire port_we_w = bus_i.wr && (rgn_w == RGN_PORT);
  wire wsel_w    = pint_we_w && (off_w[OFFW-1:5] == SRC_HI);
  wire wpin_w    = (off_w[OFFW-1:8] == WPIN_HI);
  wire [5:0] wpin_idx_w = off_w[7:2];
  wire [NCH-1:0] wd_ch_w = wd_w[NCH-1:0];

  // absent pins read as zero and cannot be driven
  wire [NPIN-1:0] pin_w = sync2_r & PIN_PRESENT;
  // inputs show the pin, outputs show what is driven
  wire [NPIN-1:0] pin_rd_w = (dir_r & out_r) | (~dir_r & pin_w);

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser and previous sample
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
    end else begin
      sync1_r <= pin_in_i;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port output next value: word pin, whole port, set, clear, toggle
  wire [NPIN-1:0] wpin_mask_w = {{(NPIN-1){1'b0}}, 1'b1} << wpin_idx_w;
  wire [NPIN-1:0] wd_a_w = {{PORTW{1'b0}}, wd_w};
  wire [NPIN-1:0] wd_b_w = {wd_w, {PORTW{1'b0}}};
  wire [NPIN-1:0] out_wpin_w = (out_r & ~wpin_mask_w) |
                               ({NPIN{|wd_w}} & wpin_mask_w);
  always_comb begin
    out_nxt = out_r;
    if (port_we_w) begin
      if (wpin_w) out_nxt = out_wpin_w;
      if (off_w == POFF_PIN_A) out_nxt[PORTW-1:0]    = wd_w;
      if (off_w == POFF_PIN_B) out_nxt[NPIN-1:PORTW] = wd_w;
      if (off_w == POFF_SET_A) out_nxt = out_r | wd_a_w;
      if (off_w == POFF_SET_B) out_nxt = out_r | wd_b_w;
      if (off_w == POFF_CLR_A) out_nxt = out_r & ~wd_a_w;
      if (off_w == POFF_CLR_B) out_nxt = out_r & ~wd_b_w;
      if (off_w == POFF_NOT_A) out_nxt = out_r ^ wd_a_w;
      if (off_w == POFF_NOT_B) out_nxt = out_r ^ wd_b_w;
    end
    out_nxt = out_nxt & PIN_PRESENT;
  end

  // direction and output data, all pins inputs after reset
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dir_r <= '0;
      out_r <= '0;
    end else begin
      out_r <= out_nxt;
      if (port_we_w && off_w == POFF_DIR_A)
        dir_r[PORTW-1:0] <= wd_w & PIN_PRESENT[PORTW-1:0];
      if (port_we_w && off_w == POFF_DIR_B)
        dir_r[NPIN-1:PORTW] <= wd_w & PIN_PRESENT[NPIN-1:PORTW];
    end
  end
  assign pin_out_o = out_r;
  assign pin_oe_o  = dir_r;

  ////////////////////////////////////////////////////////////////////////////
  // enable registers with their set and clear aliases
  wire wr_enr_w = pint_we_w && (off_w == OFF_ENR);
  wire wr_enf_w = pint_we_w && (off_w == OFF_ENF);
  assign enr_nxt = wr_enr_w ? wd_ch_w :
    (pint_we_w && off_w == OFF_ENR_SET) ? (enr_r | wd_ch_w) :
    (pint_we_w && off_w == OFF_ENR_CLR) ? (enr_r & ~wd_ch_w) : enr_r;
  assign enf_nxt = wr_enf_w ? wd_ch_w :
    (pint_we_w && off_w == OFF_ENF_SET) ? (enf_r | wd_ch_w) :
    (pint_we_w && off_w == OFF_ENF_CLR) ? (enf_r & ~wd_ch_w) : enf_r;

  // per-channel source routing and event detection
  for (genvar n = 0; n < NCH; n++) begin : g_ch
    wire [SRCW-1:0] sel_w = src_r[n];
    assign ch_lvl_w[n] = pin_w[sel_w];
    assign ch_rev_w[n] = pin_w[sel_w] & ~prev_r[sel_w];
    assign ch_fev_w[n] = ~pin_w[sel_w] & prev_r[sel_w];
  end

  // clearing writes of ones lose to an edge in the same cycle
  wire [NCH-1:0] edge_m_w = ~edge_level_select_r;
  wire [NCH-1:0] rise_clr_w = {NCH{pint_we_w && off_w == OFF_RISE}} & wd_ch_w;
  wire [NCH-1:0] fall_clr_w = {NCH{pint_we_w && off_w == OFF_FALL}} & wd_ch_w;
  wire [NCH-1:0] ist_clr_w  = {NCH{pint_we_w && off_w == OFF_IST}} & wd_ch_w;
  wire [NCH-1:0] rise_hit_w = edge_m_w & enr_r & ch_rev_w;
  wire [NCH-1:0] fall_hit_w = edge_m_w & enf_r & ch_fev_w;
  // level mode: falling enable 1 means active high, 0 active low
  wire [NCH-1:0] lvl_act_w  = edge_level_select_r & enr_r & ~(ch_lvl_w ^ enf_r);
  assign rise_nxt = rise_hit_w | (rise_r & ~rise_clr_w);
  assign fall_nxt = fall_hit_w | (fall_r & ~fall_clr_w);
  assign ist_nxt  = lvl_act_w | (edge_m_w & (rise_hit_w | fall_hit_w |
                    (ist_r & ~ist_clr_w)));

  // channel configuration and status
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      edge_level_select_r <= '0;
      enr_r  <= '0;
      enf_r  <= '0;
      rise_r <= '0;
      fall_r <= '0;
      ist_r  <= '0;
    end else begin
      enr_r  <= enr_nxt;
      enf_r  <= enf_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
      ist_r  <= ist_nxt;
      if (pint_we_w && off_w == OFF_SEL) edge_level_select_r <= wd_ch_w;
    end
  end

  // source select storage, one word per channel
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NCH; i++) src_r[i] <= '0;
    end else if (wsel_w) begin
      src_r[off_w[4:2]] <= wd_w[SRCW-1:0];
    end
  end
  assign pint_irq_o = ist_r;

  ////////////////////////////////////////////////////////////////////////////
  // two grouped blocks, identical and independent
  gpgi_group u_grp0 (
    .ref_clk_i  (ref_clk_i),
    .resetn_i   (resetn_i),
    .pin_sync_i (pin_w),
    .pin_raw_i  (pin_in_i & PIN_PRESENT),
    .sleep_i    (sleep_i),
    .we_i       (bus_i.wr && rgn_w == RGN_GRP0),
    .off_i      (off_w),
    .wdata_i    (wd_w),
    .rdata_o    (grp0_rd_w),
    .irq_o      (grp_irq_w[0]),
    .wake_o     (grp_wake_o[0])
  );
  gpgi_group u_grp1 (
    .ref_clk_i  (ref_clk_i),
    .resetn_i   (resetn_i),
    .pin_sync_i (pin_w),
    .pin_raw_i  (pin_in_i & PIN_PRESENT),
    .sleep_i    (sleep_i),
    .we_i       (bus_i.wr && rgn_w == RGN_GRP1),
    .off_i      (off_w),
    .wdata_i    (wd_w),
    .rdata_o    (grp1_rd_w),
    .irq_o      (grp_irq_w[1]),
    .wake_o     (grp_wake_o[1])
  );
  assign grp_irq_o = grp_irq_w;

  ////////////////////////////////////////////////////////////////////////////
  // read selection; write-only and unmapped words read zero
  wire [PORTW-1:0] pint_rd_w =
    (off_w == OFF_SEL)  ? {24'h000000, edge_level_select_r} :
    (off_w == OFF_ENR)  ? {24'h000000, enr_r} :
    (off_w == OFF_ENF)  ? {24'h000000, enf_r} :
    (off_w == OFF_RISE) ? {24'h000000, rise_r} :
    (off_w == OFF_FALL) ? {24'h000000, fall_r} :
    (off_w == OFF_IST)  ? {24'h000000, ist_r} :
    (off_w[OFFW-1:5] == SRC_HI) ? {26'h0000000, src_r[off_w[4:2]]} :
    32'h00000000;
  wire [PORTW-1:0] port_rd_w =
    wpin_w ? {PORTW{pin_rd_w[wpin_idx_w]}} :
    (off_w == POFF_DIR_A) ? dir_r[PORTW-1:0] :
    (off_w == POFF_DIR_B) ? dir_r[NPIN-1:PORTW] :
    (off_w == POFF_PIN_A) ? pin_rd_w[PORTW-1:0] :
    (off_w == POFF_PIN_B) ? pin_rd_w[NPIN-1:PORTW] :
    (off_w == POFF_SET_A) ? out_r[PORTW-1:0] :
    (off_w == POFF_SET_B) ? out_r[NPIN-1:PORTW] : 32'h00000000;
  wire [PORTW-1:0] rd_mux_w =
    (rgn_w == RGN_PINT) ? pint_rd_w :
    (rgn_w == RGN_GRP0) ? grp0_rd_w :
    (rgn_w == RGN_GRP1) ? grp1_rd_w : port_rd_w;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) rdata_r <= '0;
    else           rdata_r <= bus_i.rd ? rd_mux_w : 32'h00000000;
  end
  assign rdata_o = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_ch_rise(int k);
    edge_m_w[k] && enr_r[k] && ch_rev_w[k];
  endsequence
  for (genvar k = 0; k < NCH; k++) begin : g_chk
    a_edge_pending: assert property (@(posedge ref_clk_i)
      disable iff (!resetn_i) s_ch_rise(k) |=> (ist_r[k] && rise_r[k]))
      else $error("enabled rising edge not recorded");
  end
  a_rec_sticky: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    1'b1 |=> ((($past(rise_r) & ~$past(rise_clr_w)) & ~rise_r) == 8'h00))
    else $error("rising record dropped without clear");
  a_level_follow: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i) 1'b1 |=> ((ist_r & edge_level_select_r) ==
      ($past(lvl_act_w) & edge_level_select_r)) || $changed(edge_level_select_r))
    else $error("level status does not follow pin");
  a_sync_two: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    ($past(resetn_i) && $past(resetn_i, 2)) |->
      sync2_r == $past(pin_in_i, 2))
    else $error("synchroniser latency is not two cycles");
  a_set_alias: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i) (pint_we_w && off_w == OFF_ENR_SET) |=>
      ((enr_r & $past(wd_ch_w)) == $past(wd_ch_w)))
    else $error("rising enable set alias failed");
  a_port_clear: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i) (port_we_w && off_w == POFF_CLR_A) |=>
      ((out_r[PORTW-1:0] & $past(wd_w)) == 32'h00000000))
    else $error("port clear left bits set");
  a_read_window: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i) !bus_i.rd |=> (rdata_o == 32'h00000000))
    else $error("read data outside its cycle");
endmodule : gpgi_top
`default_nettype wire

// ### verif/gpgi_pins.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// outside world on the pins; a pin nobody drives floats up to its pull-up
module gpgi_pins
  import gpgi_pkg::*;
(
  // design side
  input  wire logic [NPIN-1:0] pin_out_i,
  input  wire logic [NPIN-1:0] pin_oe_i,
  // stimulus side
  input  wire logic [NPIN-1:0] drv_en_i,
  input  wire logic [NPIN-1:0] drv_val_i,
  // resolved level fed back to the design
  output logic [NPIN-1:0]      level_o
);
  // device output wins; released lines read high, never a stale value
  assign level_o = (pin_oe_i & pin_out_i)
                 | (~pin_oe_i & drv_en_i & drv_val_i)
                 | (~pin_oe_i & ~drv_en_i);
endmodule : gpgi_pins

`default_nettype wire

// ### verif/gpgi_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

////////////////////////////////////////////////////////////////////////////////
module gpgi_top_test;
  import gpgi_pkg::*;
  logic              clk = 1'b0;
  logic              resetn;
  logic              sleep;
  gpgi_bus_type      bus;
  logic [PORTW-1:0]  rdata, e, d, o, s, c, t, v;
  logic [NPIN-1:0]   lvl, pout, poe, drv_en, drv_val;
  logic [NCH-1:0]    pint_irq;
  logic [1:0]        grp_irq, grp_wake;
  logic              rd_seen, b;
  logic [PORTW-1:0]  expq[$];
  int                fails, checked, i;
  // pin 63 left absent so that a reserved bit is exercised
  localparam logic [NPIN-1:0] PRESENT = 64'h7FFFFFFFFFFFFFFF;

  always #25 clk = ~clk;

  gpgi_top #(.PIN_PRESENT(PRESENT)) u_gpgi_top (.ref_clk_i(clk),
    .resetn_i(resetn), .bus_i(bus),
    .rdata_o(rdata), .pin_in_i(lvl), .pin_out_o(pout), .pin_oe_o(poe),
    .sleep_i(sleep), .pint_irq_o(pint_irq), .grp_irq_o(grp_irq),
    .grp_wake_o(grp_wake));
  gpgi_pins u_gpgi_pins (.pin_out_i(pout), .pin_oe_i(poe),
    .drv_en_i(drv_en), .drv_val_i(drv_val), .level_o(lvl));

  // bus cycles: each edge rewrites the whole request, so strobes stay 1 cycle
  task automatic wr(input logic [AW-1:0] a, input logic [PORTW-1:0] x);
    @(posedge clk);
    bus <= '{1'b1, 1'b0, a, x};
  endtask : wr
  task automatic rd(input logic [AW-1:0] a, input logic [PORTW-1:0] x);
    @(posedge clk);
    bus <= '{1'b0, 1'b1, a, '0};
    expq.push_back(x);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      bus <= '0;
    end
  endtask : idle
  task automatic pins(input logic [NPIN-1:0] x);
    @(posedge clk);
    bus     <= '0;
    drv_val <= x;
  endtask : pins
  task automatic end_sim;
    if (fails == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen) begin
      e = expq.pop_front();
      `CHK(rdata, e)
    end
    rd_seen <= bus.rd;
  end

  // generous bound: the sequence needs under two hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    end_sim();
  end

  initial begin
    bus = '0; sleep = 1'b0; drv_en = '1; drv_val = '0; resetn = 1'b0;
    fails = 0; checked = 0; rd_seen = 1'b0;
    void'($urandom(62357));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    `CHK(poe, 64'h0)
    // reset values, write-only and unmapped places read zero
    for (i = 0; i < 10; i++) rd({RGN_PINT, OFF_SEL + 14'(4 * i)}, '0);
    rd({RGN_GRP0, GOFF_POL_A}, POL_RST);
    rd({RGN_GRP1, GOFF_POL_B}, POL_RST);
    rd({RGN_GRP0, GOFF_ENA_A}, '0);
    rd({RGN_PORT, POFF_DIR_B}, '0);
    rd(16'h0100, '0);
    // set and clear aliases of both enable registers
    s = $urandom & 32'hFF;
    c = $urandom & 32'hFF;
    wr({RGN_PINT, OFF_ENR_SET}, s);
    wr({RGN_PINT, OFF_ENR_CLR}, c);
    wr({RGN_PINT, OFF_ENF_SET}, c);
    wr({RGN_PINT, OFF_ENF_CLR}, s);
    rd({RGN_PINT, OFF_ENR}, s & ~c);
    rd({RGN_PINT, OFF_ENF}, c & ~s);
    wr({RGN_PINT, OFF_ENR}, '0);
    wr({RGN_PINT, OFF_ENF}, '0);
    // port: direction, whole word, set/clear/toggle, one word pin
    d = $urandom; o = $urandom; s = $urandom; c = $urandom; t = $urandom;
    i = $urandom % 32;
    wr({RGN_PORT, POFF_DIR_A}, d);
    wr({RGN_PORT, POFF_PIN_A}, o);
    wr({RGN_PORT, POFF_SET_A}, s);
    wr({RGN_PORT, POFF_CLR_A}, c);
    wr({RGN_PORT, POFF_NOT_A}, t);
    wr({RGN_PORT, 14'h1000 + 14'(4 * i)}, 32'h1);
    o = ((o | s) & ~c) ^ t;
    o[i] = 1'b1;
    v = $urandom;
    pins({32'h0, v});
    idle(4);
    rd({RGN_PORT, POFF_SET_A}, o);
    rd({RGN_PORT, POFF_PIN_A}, (o & d) | (v & ~d));
    b = d[i] ? o[i] : v[i];
    rd({RGN_PORT, 14'h1000 + 14'(4 * i)}, {PORTW{b}});
    idle(2);
    `CHK(poe[31:0], d)
    `CHK(pout[31:0] & d, o & d)
    // port B stays input, so these output bits never reach the pins
    wr({RGN_PORT, POFF_NOT_B}, s);
    rd({RGN_PORT, POFF_SET_B}, s & PRESENT[NPIN-1:PORTW]);
    wr({RGN_PORT, POFF_CLR_B}, s);
    rd({RGN_PORT, POFF_SET_B}, '0);
    wr({RGN_PORT, POFF_DIR_A}, '0);
    pins(64'h1 << 40);
    idle(4);
    // edge channels: ch0 rising on pin 5, ch1 falling on pin 40
    wr({RGN_PINT, 14'h0040}, 32'd5);
    wr({RGN_PINT, 14'h0044}, 32'd40);
    wr({RGN_PINT, OFF_ENR_SET}, 32'h1);
    wr({RGN_PINT, OFF_ENF_SET}, 32'h2);
    pins(64'h1 << 5);
    idle(5);
    `CHK(pint_irq, 8'h03)
    rd({RGN_PINT, OFF_RISE}, 32'h1);
    rd({RGN_PINT, OFF_FALL}, 32'h2);
    rd({RGN_PINT, OFF_IST}, 32'h3);
    pins('0); // falling edge of ch0 is not enabled
    idle(5);
    rd({RGN_PINT, OFF_FALL}, 32'h2);
    wr({RGN_PINT, OFF_RISE}, 32'hFF);
    wr({RGN_PINT, OFF_FALL}, 32'hFF);
    wr({RGN_PINT, OFF_IST}, 32'hFF);
    idle(2);
    rd({RGN_PINT, OFF_RISE}, '0);
    rd({RGN_PINT, OFF_IST}, '0);
    `CHK(pint_irq, 8'h00)
    // level channel 2 on pin 7, high then low active
    wr({RGN_PINT, OFF_SEL}, 32'h4);
    wr({RGN_PINT, 14'h0048}, 32'd7);
    wr({RGN_PINT, OFF_ENR_SET}, 32'h4);
    wr({RGN_PINT, OFF_ENF_SET}, 32'h4);
    pins(64'h1 << 7);
    idle(5);
    `CHK(pint_irq, 8'h04)
    pins('0);
    idle(5);
    `CHK(pint_irq, 8'h00)
    wr({RGN_PINT, OFF_ENF_CLR}, 32'h4);
    idle(5);
    `CHK(pint_irq, 8'h04)
    wr({RGN_PINT, OFF_ENR_CLR}, 32'h4);
    idle(5);
    `CHK(pint_irq, 8'h00)
    // first group: pin 3 low-active AND pin 4 high-active, edge trigger
    // combine mode goes in first: under the default OR, pin 3 alone
    // would already fire the edge request
    wr({RGN_GRP0, GOFF_POL_A}, 32'hFFFFFFF7);
    wr({RGN_GRP0, GOFF_CTRL}, 32'h2);
    wr({RGN_GRP0, GOFF_ENA_A}, 32'h18);
    idle(3);
    `CHK(grp_irq, 2'b00)
    sleep <= 1'b1;
    pins(64'h1 << 4);
    idle(5);
    `CHK(grp_irq, 2'b01)
    `CHK(grp_wake, 2'b01)
    wr({RGN_GRP0, GOFF_CTRL}, 32'h3);
    idle(3);
    `CHK(grp_irq, 2'b00)
    // second group: pin 40 alone, OR, level trigger
    wr({RGN_GRP1, GOFF_ENA_B}, 32'h100);
    wr({RGN_GRP1, GOFF_CTRL}, 32'h4);
    pins((64'h1 << 40) | (64'h1 << 4));
    idle(5);
    `CHK(grp_irq, 2'b10)
    `CHK(grp_wake, 2'b11)
    // level trigger: a clear while the pattern holds is set again at once
    wr({RGN_GRP1, GOFF_CTRL}, 32'h5);
    sleep <= 1'b0;
    idle(3);
    `CHK(grp_irq, 2'b10)
    `CHK(grp_wake, 2'b00)
    // the request outlives the pattern until software clears it
    pins('0);
    idle(5);
    `CHK(grp_irq, 2'b10)
    wr({RGN_GRP1, GOFF_CTRL}, 32'h5);
    idle(3);
    `CHK(grp_irq, 2'b00)
    idle(3);
    end_sim();
  end
endmodule : gpgi_top_test

`default_nettype wire
